//--- design/upr_ctrl_if.sv
// control bits carried from the register file to the termination logic
`timescale 1ns/1ps
interface upr_ctrl_if;
    logic module_enable_bit;
    logic module_power_bit;
    logic host_mode_enable;
    logic otg_override_enable;
    logic dplus_pullup_ctrl;
    logic dplus_pulldown_ctrl;
    logic dminus_pulldown_ctrl;
    logic suspend;
    modport src (output module_enable_bit, module_power_bit,
        host_mode_enable, otg_override_enable, dplus_pullup_ctrl,
        dplus_pulldown_ctrl, dminus_pulldown_ctrl, suspend);
    modport dst (input module_enable_bit, module_power_bit,
        host_mode_enable, otg_override_enable, dplus_pullup_ctrl,
        dplus_pulldown_ctrl, dminus_pulldown_ctrl, suspend);
endinterface

//--- design/upr_defines.svh
// register offsets, field positions, reset values for pull resistor control
`ifndef UPR_DEFINES_SVH
`define UPR_DEFINES_SVH
`define UPR_OFS_USB_CTRL 8'h00
`define UPR_OFS_OTG_CTRL 8'h04
`define UPR_OFS_PWR_CTRL 8'h08
`define UPR_OFS_STATUS 8'h0C
`define UPR_BIT_MOD_EN 0
`define UPR_BIT_HOST_EN 3
`define UPR_BIT_OTG_EN 2
`define UPR_BIT_DP_PD 4
`define UPR_BIT_DM_PD 5
`define UPR_BIT_DP_PU 7
`define UPR_BIT_MOD_PWR 0
`define UPR_BIT_SUSPEND 1
`define UPR_RST_CTRL 8'h00
`endif

//--- design/upr_pkg.sv
// types shared by the pull resistor control block
package upr_pkg;
    typedef struct packed {
        logic dplus_pullup;
        logic dplus_pulldown;
        logic dminus_pulldown;
    } upr_term_t;
    typedef enum logic [1:0] {
        UPR_IDLE = 2'b00,
        UPR_ACK = 2'b01
    } upr_bus_state_t;
endpackage

//--- design/upr_term_logic.sv
// termination decision logic with registered enable outputs
`timescale 1ns/1ps
module upr_term_logic
    import upr_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // control bits and synchronised session level
    upr_ctrl_if.dst ctrl,
    input wire logic session_valid,
    // registered terminations
    output upr_term_t term
);
    upr_term_t term_reg;
    upr_term_t term_next;
    wire logic dev_pullup;
    wire logic host_pd;
    // device-mode pull-up excludes host mode
    assign dev_pullup = ctrl.module_enable_bit & ctrl.module_power_bit
        & ~ctrl.host_mode_enable;
    assign host_pd = ctrl.host_mode_enable;
    // suspend is deliberately not an input term here
    always_comb
    begin
        term_next.dplus_pullup = (ctrl.otg_override_enable
            ? ctrl.dplus_pullup_ctrl
            : dev_pullup) & session_valid;
        term_next.dplus_pulldown = ctrl.otg_override_enable
            ? ctrl.dplus_pulldown_ctrl : host_pd;
        term_next.dminus_pulldown = ctrl.otg_override_enable
            ? ctrl.dminus_pulldown_ctrl : host_pd;
    end
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            term_reg <= '0;
        else
            term_reg <= term_next;
    end
    assign term = term_reg;
endmodule

//--- design/upr_top.sv
// wishbone register file and top of the pull resistor control block
//
// Our own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`include "upr_defines.svh"
module upr_top
    import upr_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // vbus comparator, asynchronous
    input wire logic vbus_session_valid,
    // termination enables
    output logic dplus_pullup_en,
    output logic dplus_pulldown_en,
    output logic dminus_pulldown_en
);
    ////////////////////////////////////////////////////////////////////////
    logic [7:0] usb_control_reg;
    logic [7:0] otg_control_reg;
    logic [7:0] pwr_control_reg;
    logic [31:0] rdata_reg;
    logic ack_reg;
    logic sess_meta_reg;
    logic sess_sync_reg;
    upr_term_t term;
    upr_ctrl_if ctrl_bus ();
    wire logic req;
    wire logic wr_lane0;
    wire logic sel_usb;
    wire logic sel_otg;
    wire logic sel_pwr;
    wire logic sel_sts;
    wire logic [31:0] rd_mux;
    // one wait state, then ack drops for a cycle even if stb stays
    assign req = wb_cyc_i & wb_stb_i & ~ack_reg;
    assign wr_lane0 = req & wb_we_i & wb_sel_i[0];
    assign sel_usb = wb_adr_i == `UPR_OFS_USB_CTRL;
    assign sel_otg = wb_adr_i == `UPR_OFS_OTG_CTRL;
    assign sel_pwr = wb_adr_i == `UPR_OFS_PWR_CTRL;
    assign sel_sts = wb_adr_i == `UPR_OFS_STATUS;
    // unmapped offsets read zero and writes are dropped
    assign rd_mux = sel_usb ? {24'h00_0000, usb_control_reg}
        : sel_otg ? {24'h00_0000, otg_control_reg}
        : sel_pwr ? {24'h00_0000, pwr_control_reg}
        : sel_sts ? {28'h000_0000, sess_sync_reg, term.dminus_pulldown,
            term.dplus_pulldown, term.dplus_pullup}
        : 32'h0000_0000;
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            usb_control_reg <= `UPR_RST_CTRL;
            otg_control_reg <= `UPR_RST_CTRL;
            pwr_control_reg <= `UPR_RST_CTRL;
        end
        else if (wr_lane0)
        begin
            if (sel_usb)
                usb_control_reg <= wb_dat_i[7:0];
            if (sel_otg)
                otg_control_reg <= wb_dat_i[7:0];
            if (sel_pwr)
                pwr_control_reg <= wb_dat_i[7:0];
        end
    end
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end
        else
        begin
            ack_reg <= req;
            if (req)
                rdata_reg <= rd_mux;
        end
    end
    // session level comes from an analog comparator
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            sess_meta_reg <= 1'b0;
            sess_sync_reg <= 1'b0;
        end
        else
        begin
            sess_meta_reg <= vbus_session_valid;
            sess_sync_reg <= sess_meta_reg;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    assign ctrl_bus.module_enable_bit = usb_control_reg[`UPR_BIT_MOD_EN];
    assign ctrl_bus.host_mode_enable = usb_control_reg[`UPR_BIT_HOST_EN];
    assign ctrl_bus.otg_override_enable = otg_control_reg[`UPR_BIT_OTG_EN];
    assign ctrl_bus.dplus_pullup_ctrl = otg_control_reg[`UPR_BIT_DP_PU];
    assign ctrl_bus.dplus_pulldown_ctrl = otg_control_reg[`UPR_BIT_DP_PD];
    assign ctrl_bus.dminus_pulldown_ctrl = otg_control_reg[`UPR_BIT_DM_PD];
    assign ctrl_bus.module_power_bit = pwr_control_reg[`UPR_BIT_MOD_PWR];
    assign ctrl_bus.suspend = pwr_control_reg[`UPR_BIT_SUSPEND];
    upr_term_logic u_term (
        .clk_sys(clk_sys),
        .rst(rst),
        .ctrl(ctrl_bus),
        .session_valid(sess_sync_reg),
        .term(term)
    );
    assign dplus_pullup_en = term.dplus_pullup;
    assign dplus_pulldown_en = term.dplus_pulldown;
    assign dminus_pulldown_en = term.dminus_pulldown;
    assign wb_dat_o = rdata_reg;
    assign wb_ack_o = ack_reg;
endmodule

//--- sim/upr_top_asserts.sv
// concurrent checks on the pull resistor control ports
`timescale 1ns/1ps
module upr_top_asserts (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    // vbus and terminations
    input wire logic vbus_session_valid,
    input wire logic dplus_pullup_en,
    input wire logic dplus_pulldown_en,
    input wire logic dminus_pulldown_en
);
    logic [7:0] usb_reg;
    logic [7:0] otg_reg;
    logic pwr_reg;
    // shadows follow writes at the taking edge
    wire req = wb_cyc_i && wb_stb_i;
    wire wr = req && !wb_ack_o && wb_we_i && wb_sel_i[0];
    wire ovr = otg_reg[2];
    wire exp_pu = ovr ? otg_reg[7] : usb_reg[0] && pwr_reg && !usb_reg[3];
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst) {usb_reg, otg_reg, pwr_reg} <= '0;
        else if (wr && wb_adr_i == 8'h00) usb_reg <= wb_dat_i[7:0];
        else if (wr && wb_adr_i == 8'h04) otg_reg <= wb_dat_i[7:0];
        else if (wr && wb_adr_i == 8'h08) pwr_reg <= wb_dat_i[0];
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack wider than one cycle");
    chk_ack_answer: assert property (req && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing");
    chk_dp_pulldown: assert property (
        dplus_pulldown_en == $past(ovr ? otg_reg[4] : usb_reg[3]))
        else $error("d+ pull-down wrong");
    chk_dm_pulldown: assert property (
        dminus_pulldown_en == $past(ovr ? otg_reg[5] : usb_reg[3]))
        else $error("d- pull-down wrong");
    chk_pu_source: assert property (
        dplus_pullup_en |-> $past(exp_pu))
        else $error("pull-up without cause");
    chk_pu_session: assert property (
        !vbus_session_valid [*3] |=> !dplus_pullup_en)
        else $error("pull-up kept without vbus");
    chk_pu_hold: assert property (
        (vbus_session_valid && exp_pu) [*4] |=> dplus_pullup_en)
        else $error("pull-up not engaged");
    chk_reset_off: assert property ($fell(rst) |->
        !(dplus_pullup_en || dplus_pulldown_en || dminus_pulldown_en))
        else $error("termination on out of reset");
    cover property (ovr && dplus_pulldown_en && !dminus_pulldown_en);
    cover property (!ovr && dminus_pulldown_en);
    cover property ($fell(dplus_pullup_en));
endmodule
bind upr_top upr_top_asserts i_chk (.clk_sys, .rst, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .vbus_session_valid,
    .dplus_pullup_en, .dplus_pulldown_en, .dminus_pulldown_en);

//--- sim/upr_top_tb_top.sv
// self-checking bench for the pull resistor control block
`timescale 1ns/1ps
module upr_top_tb_top;
    logic clk_sys = 0, rst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic host_on = 0, wb_ack_o, vbus_session_valid, pu, dp, dm;
    logic [3:0] wb_sel_i = 4'h1;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, q;
    logic [7:0] ov [5] = '{8'h04, 8'h14, 8'h24, 8'h84, 8'hB4};
    logic [2:0] ex [5] = '{3'h0, 3'h2, 3'h1, 3'h4, 3'h7};
    int err_total = 0, cmp_count = 0;
    upr_usb_host_model i_host (.power_on(host_on), .vbus_session_valid);
    upr_top i_dut (.clk_sys, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .vbus_session_valid,
        .dplus_pullup_en(pu), .dplus_pulldown_en(dp), .dminus_pulldown_en(dm));
    task automatic chk(input string s, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e)
        begin
            err_total++;
            $display("CHECK FAILED %s exp %0h got %0h", s, e, g);
        end
    endtask
    // no local limit: only the watchdog may end a wait for ack
    task automatic bus(input logic w, input logic [7:0] a, d);
        @(posedge clk_sys);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i} <= {2'b11, w, a};
        wb_dat_i <= 32'(d);
        do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask
    // vbus needs three edges to reach the pull-up, so wait four
    task automatic pins(input logic [2:0] e);
        repeat (4) @(posedge clk_sys);
        chk("pins", 32'(e), 32'({pu, dp, dm}));
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial forever #20 clk_sys = ~clk_sys;
    initial
    begin
        #100000;
        err_total++;
        final_report;
    end
    initial
    begin
        repeat (12) @(posedge clk_sys);
        rst <= 0;
        for (int a = 0; a < 20; a += 4)
        begin
            bus(0, 8'(a), 0);
            chk("reset read", 0, q);
        end
        pins(3'h0);
        $display("test reset done");
        host_on <= 1;
        bus(1, 8'h00, 8'h01);
        pins(3'h0);
        bus(1, 8'h08, 8'h03);
        pins(3'h4);
        bus(0, 8'h0C, 0);
        chk("status", 32'h0000_0009, q);
        host_on <= 0;
        pins(3'h0);
        host_on <= 1;
        bus(1, 8'h00, 8'h09);
        pins(3'h3);
        $display("test default mode done");
        for (int i = 0; i < 5; i++)
        begin
            bus(1, 8'h04, ov[i]);
            pins(ex[i]);
        end
        wb_sel_i <= 4'h0;
        bus(1, 8'h04, 8'h00);
        wb_sel_i <= 4'h1;
        bus(0, 8'h04, 0);
        chk("override read", 32'h0000_00B4, q);
        bus(1, 8'h10, 8'hFF);
        bus(0, 8'h10, 0);
        chk("unmapped read", 0, q);
        host_on <= 0;
        pins(3'h3);
        $display("test override done");
        rst <= 1;
        pins(3'h0);
        rst <= 0;
        bus(0, 8'h04, 0);
        chk("after reset", 0, q);
        host_on <= 1;
        // pull bits without override must not reach the lines
        bus(1, 8'h04, 8'hB0);
        bus(1, 8'h00, 8'h01);
        bus(1, 8'h08, 8'h01);
        pins(3'h4);
        $display("test second reset done");
        final_report;
    end
endmodule

//--- sim/upr_usb_host_model.sv
// far side usb host: switches vbus, seen through the session comparator
`timescale 1ns/1ps
module upr_usb_host_model (
    // host power request
    input wire logic power_on,
    // comparator level toward the device
    output logic vbus_session_valid
);
    assign vbus_session_valid = power_on;
endmodule
